// file: irq_wake_pkg.sv
/*
 * constants for the interrupt and wakeup control block: register offsets, field positions,
 * reset values, mode codes and wakeup timing.
 * assumes nothing of its surroundings.
 */
package irq_wake_pkg;

    // register byte addresses: every printed offset keeps its index, byte address is four times it
    localparam logic [7:0]  IDX_IRQ_FLAGS  = 8'hC8;
    localparam logic [7:0]  IDX_IRQ_ENABLE = 8'hC9;
    localparam logic [7:0]  IDX_OSC_MODE   = 8'hCA;
    localparam logic [7:0]  IDX_STACK_GIE  = 8'hDF;
    localparam logic [7:0]  IDX_PUSH_DATA  = 8'hE0;
    localparam logic [11:0] ADDR_IRQ_FLAGS  = {2'h0, IDX_IRQ_FLAGS, 2'h0};
    localparam logic [11:0] ADDR_IRQ_ENABLE = {2'h0, IDX_IRQ_ENABLE, 2'h0};
    localparam logic [11:0] ADDR_OSC_MODE   = {2'h0, IDX_OSC_MODE, 2'h0};
    localparam logic [11:0] ADDR_STACK_GIE  = {2'h0, IDX_STACK_GIE, 2'h0};
    localparam logic [11:0] ADDR_PUSH_DATA  = {2'h0, IDX_PUSH_DATA, 2'h0};

    // source bit positions in the flag and enable registers
    localparam int BIT_EXT   = 0;
    localparam int BIT_WAKE  = 2;
    localparam int BIT_TIMER = 4;
    localparam int BIT_USB   = 6;
    localparam logic [7:0] SRC_MASK = 8'h55;

    // stack register fields
    localparam int BIT_GIE = 7;
    localparam logic [7:0] STACK_RESET = 8'h07;
    localparam logic [7:0] STACK_MASK  = 8'h87;

    // oscillator mode register fields
    localparam int BIT_STOP   = 1;
    localparam int BIT_CLOCK_MODE_SELECT  = 2;
    localparam int BIT_OPMODE = 3;
    localparam logic [7:0] OSC_MASK  = 8'h1E;
    localparam logic [7:0] OSC_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;

    // operating mode codes
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_SLEEP  = 2'h1;
    localparam logic [1:0] OPM_GREEN  = 2'h2;
    localparam logic [1:0] OPM_RSVD   = 2'h3;

    // interrupt vector
    localparam logic [11:0] IRQ_VECTOR = 12'h008;

    // program flags bits excluded from save/restore: timeout and power-down status
    localparam logic [7:0] PROGRAM_FLAGS_KEEP_MASK = 8'hCF;

    // wakeup hold-off
    localparam int WAKE_SYS_PERIODS = 2048;
    localparam int OSC_START_NS     = 1000;
    localparam int PCLK_NS          = 40;
    localparam int OSC_START_CYC    = (OSC_START_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int WAKE_HOLD_CYC    = WAKE_SYS_PERIODS + OSC_START_CYC;

endpackage

// file: cpu_side_if.sv
/*
 * carrier between the register front end and the mode/vector core.
 * assumes both ends sit on pclk.
 */
`timescale 1ns/10ps
interface cpu_side_if;
    logic       wr_stb;
    logic [2:0] wr_sel;
    logic [7:0] wr_data;
    logic [1:0] opmode;
    logic       clk_slow;
    logic       hosc_stop;
    logic       running;
    logic       wake_done;
    modport core (input wr_stb, input wr_sel, input wr_data, output opmode, output clk_slow,
                  output hosc_stop, output running, output wake_done);
    modport regs (output wr_stb, output wr_sel, output wr_data, input opmode, input clk_slow,
                  input hosc_stop, input running, input wake_done);
endinterface

// file: power_mode_fsm.sv
/*
 * power mode state machine: normal, slow, green, sleep and the wakeup hold-off.
 * assumes synchronised wake events on pclk; writes come from the register front end.
 */
`timescale 1ns/10ps
module power_mode_fsm
    import irq_wake_pkg::*;
#(
    parameter int HOLD_CYC = WAKE_HOLD_CYC
)(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // wake causes
    input  wire logic pin_wake,
    input  wire logic timer_ovf,
    input  wire logic timer_run,
    // register side
    cpu_side_if.core  bus
);
    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_GREEN = 4'b0010,
        ST_SLEEP = 4'b0100,
        ST_HOLD  = 4'b1000
    } pm_state_e;

    pm_state_e   state_q, state_d;
    logic [1:0]  opm_q, opm_d;
    logic        slow_q, slow_d;
    logic        stop_q, stop_d;
    logic [15:0] cnt_q, cnt_d;
    logic        done_q, done_d;

    always_comb
    begin
        state_d = state_q;
        opm_d   = opm_q;
        slow_d  = slow_q;
        stop_d  = stop_q;
        cnt_d   = cnt_q;
        done_d  = 1'b0;
        case (state_q)
            ST_RUN:
            begin
                if (bus.wr_stb && bus.wr_sel == 3'h2)
                begin
                    slow_d = bus.wr_data[BIT_CLOCK_MODE_SELECT];
                    stop_d = bus.wr_data[BIT_STOP];
                    opm_d  = bus.wr_data[BIT_OPMODE +: 2];
                    if (bus.wr_data[BIT_OPMODE +: 2] == OPM_SLEEP)
                        state_d = ST_SLEEP;
                    else if (bus.wr_data[BIT_OPMODE +: 2] == OPM_GREEN)
                        state_d = ST_GREEN;
                end
            end
            ST_GREEN:
            begin
                // clocks stay up, so no hold-off; slow/normal choice is left untouched
                if (pin_wake || (timer_run && timer_ovf))
                begin
                    opm_d   = OPM_NORMAL;
                    done_d  = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_SLEEP:
            begin
                if (pin_wake)
                begin
                    opm_d   = OPM_NORMAL;
                    slow_d  = 1'b0;
                    stop_d  = 1'b0;
                    cnt_d   = 16'(HOLD_CYC - 1);
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (cnt_q == 16'h0000)
                begin
                    done_d  = 1'b1;
                    state_d = ST_RUN;
                end
                else
                    cnt_d = cnt_q - 16'h0001;
            end
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_RUN;
            opm_q   <= OPM_NORMAL;
            slow_q  <= 1'b0;
            stop_q  <= 1'b0;
            cnt_q   <= 16'h0000;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            opm_q   <= opm_d;
            slow_q  <= slow_d;
            stop_q  <= stop_d;
            cnt_q   <= cnt_d;
            done_q  <= done_d;
        end
    end

    assign bus.opmode    = opm_q;
    assign bus.clk_slow  = slow_q;
    assign bus.hosc_stop = stop_q;
    assign bus.running   = (state_q == ST_RUN);
    assign bus.wake_done = done_q;

    property p_hold_len;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_SLEEP && pin_wake) |=> !bus.running [*8];
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("sleep wake ran early");

    property p_green_fast;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_GREEN && pin_wake) |=> bus.running;
    endproperty
    a_green_fast: assert property (p_green_fast) else $error("green wake delayed");

    property p_sleep_normal;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_HOLD) |-> (!slow_q && !stop_q);
    endproperty
    a_sleep_normal: assert property (p_sleep_normal) else $error("sleep wake not normal");

    property p_sleep_no_timer;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_SLEEP && !pin_wake) |=> (state_q == ST_SLEEP);
    endproperty
    a_sleep_no_timer: assert property (p_sleep_no_timer) else $error("sleep left without pin");

endmodule // power_mode_fsm

// file: irq_wake_ctrl.sv
/*
 * interrupt and wakeup controller: APB register slave, request flags and enables,
 * global enable with stack pointer, shared vector, save/restore buffer and power modes.
 * assumes the core pulses irq_ack when it takes the vector and return_from_interrupt_stb on return;
 * event inputs from pins and other logic are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
//
// Overview of operation
// - sleep code write stops clocks and execution
// - only a wake pin, ext pin or usb bus toggle event, or reset, leaves sleep
// - clock select picks low RC, stop halts high
// - green code halts execution, clocks run
// - green exits on timer overflow with timer run enable set, or wake pin, ext pin or usb bus toggle event
// - sleep wakes to normal on pins only
// - green wake restores prior normal or slow
// - sleep wake holds 2048 periods plus start-up
// - green wake resumes without delay
// - vector clears global enable, return sets it
// - enable bits 0,2,4,6 per source
// - events set sticky flags, firmware clears
// - enabled pending request pushes and jumps to 8
// - global enable bit 7, stack resets ones
// - save/restore buffer excludes status bits
// - external pin event wakes sleep to normal
// - mode codes normal, sleep, green, reserved
// - flags set regardless of enable
module irq_wake_ctrl
    import irq_wake_pkg::*;
#(
    parameter int HOLD_CYC = irq_wake_pkg::WAKE_HOLD_CYC
)(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // asynchronous events
    input  wire logic        ext_pin_event,
    input  wire logic        port_wake_event,
    input  wire logic        usb_bus_toggle,
    input  wire logic        timer_overflow,
    input  wire logic        usb_done,
    input  wire logic        timer_run_enable,
    // processor core
    input  wire logic        irq_ack,
    input  wire logic        return_from_interrupt_stb,
    input  wire logic        save_stb,
    input  wire logic        restore_stb,
    input  wire logic [7:0]  accumulator,
    input  wire logic [7:0]  program_flags,
    output logic             irq_take,
    output logic      [11:0] vector_addr,
    output logic      [2:0]  stack_ptr,
    output logic             cpu_run,
    output logic             clock_mode_select,
    output logic             high_osc_stop,
    output logic             osc_all_stop,
    output logic      [7:0]  restore_acc,
    output logic      [7:0]  restore_flags,
    output logic             restore_valid
);
    ////////////////////////////////////////////////////////////////////////////////
    cpu_side_if bus ();

    logic [5:0] s1_q, s2_q, s3_q;
    logic [5:0] sync_in;
    logic       ext_ev, pwake_ev, usbt_ev, tov_ev, usbd_ev, trun;

    assign sync_in = {timer_run_enable, usb_done, timer_overflow, usb_bus_toggle, port_wake_event, ext_pin_event};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
        end
        else
        begin
            s1_q <= sync_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // events are rising edges of synchronised levels; run enable is a level
    assign ext_ev   = s2_q[0] & ~s3_q[0];
    assign pwake_ev = s2_q[1] & ~s3_q[1];
    assign usbt_ev  = s2_q[2] & ~s3_q[2];
    assign tov_ev   = s2_q[3] & ~s3_q[3];
    assign usbd_ev  = s2_q[4] & ~s3_q[4];
    assign trun     = s2_q[5];

    logic pin_wake;
    assign pin_wake = pwake_ev | usbt_ev | ext_ev;

    power_mode_fsm #(
        .HOLD_CYC (HOLD_CYC)
    ) u_pm (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_wake  (pin_wake),
        .timer_ovf (tov_ev),
        .timer_run (trun),
        .bus       (bus.core)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] sel_of(input logic [11:0] a);
        case (a)
            ADDR_IRQ_FLAGS:  sel_of = 3'h0;
            ADDR_IRQ_ENABLE: sel_of = 3'h1;
            ADDR_OSC_MODE:   sel_of = 3'h2;
            ADDR_STACK_GIE:  sel_of = 3'h3;
            ADDR_PUSH_DATA:  sel_of = 3'h4;
            default:         sel_of = 3'h7;
        endcase
    endfunction

    logic       access, hit;
    logic [2:0] sel;
    assign access = psel & penable;
    assign sel    = sel_of(paddr);
    assign hit    = (sel != 3'h7);

    assign bus.wr_stb  = access & pwrite & hit;
    assign bus.wr_sel  = sel;
    assign bus.wr_data = pwdata[7:0];

    logic [7:0] flags_q, flags_d;
    logic [7:0] en_q, en_d;
    logic [7:0] stk_q, stk_d;
    logic       take_q, take_d;
    logic [7:0] sacc_q, sacc_d, sflg_q, sflg_d;
    logic       rval_q, rval_d;
    logic [31:0] rd_q, rd_d;
    logic        rdy_q, rdy_d, err_q, err_d;
    logic [7:0]  set_v;
    logic        pending;

    // one response cycle: setup, then access answered with pready high
    always_comb
    begin
        set_v = 8'h00;
        set_v[BIT_EXT]   = ext_ev;
        set_v[BIT_WAKE]  = pwake_ev | usbt_ev;
        set_v[BIT_TIMER] = tov_ev;
        set_v[BIT_USB]   = usbd_ev;

        flags_d = flags_q;
        if (bus.wr_stb && sel == 3'h0)
            flags_d = pwdata[7:0] & SRC_MASK;
        flags_d = flags_d | set_v;

        en_d = en_q;
        if (bus.wr_stb && sel == 3'h1)
            en_d = pwdata[7:0] & SRC_MASK;

        stk_d = stk_q;
        if (bus.wr_stb && sel == 3'h3)
            stk_d = pwdata[7:0] & STACK_MASK;
        if (irq_ack)
        begin
            stk_d[BIT_GIE] = 1'b0;
            stk_d[2:0]     = stk_q[2:0] - 3'h1;
        end
        else if (return_from_interrupt_stb)
        begin
            stk_d[BIT_GIE] = 1'b1;
            stk_d[2:0]     = stk_q[2:0] + 3'h1;
        end

        // single shared vector, firmware polls to find the source
        pending = |(flags_q & en_q);
        take_d  = stk_q[BIT_GIE] & pending & bus.running & ~irq_ack;

        sacc_d = sacc_q;
        sflg_d = sflg_q;
        rval_d = 1'b0;
        if (save_stb)
        begin
            sacc_d = accumulator;
            sflg_d = program_flags & PROGRAM_FLAGS_KEEP_MASK;
        end
        if (restore_stb)
            rval_d = 1'b1;

        rd_d  = rd_q;
        rdy_d = 1'b0;
        err_d = 1'b0;
        if (psel && !penable)
        begin
            rdy_d = 1'b1;
            err_d = ~hit;
            case (sel)
                3'h0:    rd_d = {24'h000000, flags_q};
                3'h1:    rd_d = {24'h000000, en_q};
                3'h2:    rd_d = {27'h0000000, bus.opmode, bus.clk_slow, bus.hosc_stop, 1'b0};
                3'h3:    rd_d = {24'h000000, stk_q};
                3'h4:    rd_d = {16'h0000, sflg_q, sacc_q};
                default: rd_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_q <= REG_RESET;
            en_q    <= REG_RESET;
            stk_q   <= STACK_RESET;
            take_q  <= 1'b0;
            sacc_q  <= 8'h00;
            sflg_q  <= 8'h00;
            rval_q  <= 1'b0;
            rd_q    <= 32'h00000000;
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
        end
        else
        begin
            flags_q <= flags_d;
            en_q    <= en_d;
            stk_q   <= stk_d;
            take_q  <= take_d;
            sacc_q  <= sacc_d;
            sflg_q  <= sflg_d;
            rval_q  <= rval_d;
            rd_q    <= rd_d;
            rdy_q   <= rdy_d;
            err_q   <= err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic       run_q, slow_q, stop_q, off_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q  <= 1'b1;
            slow_q <= 1'b0;
            stop_q <= 1'b0;
            off_q  <= 1'b0;
        end
        else
        begin
            run_q  <= bus.running;
            slow_q <= bus.clk_slow;
            stop_q <= bus.hosc_stop | (bus.opmode == OPM_SLEEP);
            off_q  <= (bus.opmode == OPM_SLEEP);
        end
    end

    assign prdata            = rd_q;
    assign pready            = rdy_q;
    assign pslverr           = err_q;
    assign irq_take          = take_q;
    assign vector_addr       = IRQ_VECTOR;
    assign stack_ptr         = stk_q[2:0];
    assign cpu_run           = run_q;
    assign clock_mode_select = slow_q;
    assign high_osc_stop     = stop_q;
    assign osc_all_stop      = off_q;
    assign restore_acc       = sacc_q;
    assign restore_flags     = sflg_q;
    assign restore_valid     = rval_q;

    ////////////////////////////////////////////////////////////////////////////////
    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        tov_ev |=> flags_q[BIT_TIMER];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("timer flag not set");

    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        (flags_q[BIT_USB] && !(bus.wr_stb && sel == 3'h0)) |=> flags_q[BIT_USB];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("usb flag lost");

    property p_no_take_disabled;
        @(posedge pclk) disable iff (!presetn)
        ((flags_q & en_q) == 8'h00) |=> !irq_take;
    endproperty
    a_no_take_disabled: assert property (p_no_take_disabled) else $error("vector without enable");

    property p_take;
        @(posedge pclk) disable iff (!presetn)
        (stk_q[BIT_GIE] && pending && bus.running && !irq_ack) |=> irq_take;
    endproperty
    a_take: assert property (p_take) else $error("vector not taken");

    property p_gie_clear;
        @(posedge pclk) disable iff (!presetn)
        irq_ack |=> !stk_q[BIT_GIE];
    endproperty
    a_gie_clear: assert property (p_gie_clear) else $error("global enable not cleared");

    property p_gie_set;
        @(posedge pclk) disable iff (!presetn)
        (return_from_interrupt_stb && !irq_ack) |=> stk_q[BIT_GIE];
    endproperty
    a_gie_set: assert property (p_gie_set) else $error("global enable not restored");

    property p_save;
        @(posedge pclk) disable iff (!presetn)
        save_stb |=> (restore_flags == ($past(program_flags) & PROGRAM_FLAGS_KEEP_MASK));
    endproperty
    a_save: assert property (p_save) else $error("save buffer wrong");

    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb not answered");

endmodule // irq_wake_ctrl

// file: cpu_core_model.sv
/*
 * core side model: takes the vector and returns from service on request.
 * assumes pclk domain; irq_take is a registered level from the controller.
 */
`timescale 1ns/10ps
module cpu_core_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // vector handshake
    input  wire logic irq_take,
    input  wire logic return_from_interrupt_req,
    output logic      irq_ack,
    output logic      return_from_interrupt_stb
);
    logic busy_q;
    // irq_take may linger a cycle after the ack, so only its rise is answered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ack  <= 1'b0;
            busy_q   <= 1'b0;
            return_from_interrupt_stb <= 1'b0;
        end
        else
        begin
            irq_ack  <= irq_take && !busy_q;
            busy_q   <= irq_take;
            return_from_interrupt_stb <= return_from_interrupt_req;
        end
    end
endmodule // cpu_core_model

// file: interrupt_and_wakeup_control_test.sv
/*
 * testbench: apb register access, event pulses, power mode and vector checks.
 * assumes the controller answers apb without wait states and hold-off of HOLD cycles.
 */
`timescale 1ns/10ps
module interrupt_and_wakeup_control_test;
    import irq_wake_pkg::*;
    localparam int HOLD = 16;
    // stands in for the 10 ms oscillator settle, scaled down to keep the run short
    localparam int SETTLE = 250;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, vector_addr;
    logic [31:0] pwdata, prdata, r;
    logic [4:0]  ev;
    logic trun, irq_ack, return_from_interrupt_stb, return_from_interrupt_req, save_stb, restore_stb, irq_take, cpu_run;
    logic clock_mode_select, high_osc_stop, osc_all_stop, restore_valid, e;
    logic [7:0]  acc, pf, restore_acc, restore_flags;
    logic [2:0]  sp;
    int fails, n_compared, n, i;
    int evk[4] = '{0, 1, 3, 4};
    irq_wake_ctrl #(.HOLD_CYC(HOLD)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_pin_event(ev[0]), .port_wake_event(ev[1]),
        .usb_bus_toggle(ev[2]), .timer_overflow(ev[3]), .usb_done(ev[4]), .timer_run_enable(trun),
        .irq_ack(irq_ack), .return_from_interrupt_stb(return_from_interrupt_stb), .save_stb(save_stb), .restore_stb(restore_stb),
        .accumulator(acc), .program_flags(pf), .irq_take(irq_take), .vector_addr(vector_addr),
        .stack_ptr(sp), .cpu_run(cpu_run), .clock_mode_select(clock_mode_select),
        .high_osc_stop(high_osc_stop), .osc_all_stop(osc_all_stop), .restore_acc(restore_acc),
        .restore_flags(restore_flags), .restore_valid(restore_valid));
    cpu_core_model i_core (.pclk(pclk), .presetn(presetn), .irq_take(irq_take),
        .return_from_interrupt_req(return_from_interrupt_req), .irq_ack(irq_ack), .return_from_interrupt_stb(return_from_interrupt_stb));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // one idle cycle after each transfer keeps psel from being driven twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            fails++;
            stop_test();
        end
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(r, {24'h0, x});
    endtask
    // events are asynchronous levels; six cycles cover the synchroniser
    task automatic pulse(input logic [4:0] m);
        ev <= m;
        repeat (3) @(posedge pclk);
        ev <= 5'h00;
        repeat (3) @(posedge pclk);
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return cpu_run;
            1: return irq_take;
            default: return restore_valid;
        endcase
    endfunction
    task automatic wt(input int k);
        n = 0;
        while (sig(k) !== 1'b1 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200)
        begin
            fails++;
            stop_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, ev, trun} = '0;
        {return_from_interrupt_req, save_stb, restore_stb, acc, pf, fails, n_compared} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_IRQ_FLAGS, 8'h00);
        rd(ADDR_IRQ_ENABLE, 8'h00);
        rd(ADDR_STACK_GIE, STACK_RESET);
        apb(1'b0, 12'hFF0, 8'h00);
        chk({31'h0, e}, 32'h1);
        $display("test 1 done");
        wr(ADDR_STACK_GIE, 8'h87);
        for (i = 0; i < 4; i++)
        begin
            pulse(5'h01 << evk[i]);
            rd(ADDR_IRQ_FLAGS, 8'h55 >> (6 - 2 * i));
        end
        chk({31'h0, irq_take}, 32'h0);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        rd(ADDR_IRQ_FLAGS, 8'h00);
        $display("test 2 done");
        wr(ADDR_IRQ_ENABLE, 8'h50);
        rd(ADDR_IRQ_ENABLE, 8'h50);
        pulse(5'h18);
        wt(1);
        repeat (3) @(posedge pclk);
        chk({20'h0, vector_addr}, {20'h0, IRQ_VECTOR});
        rd(ADDR_STACK_GIE, 8'h06);
        chk({29'h0, sp}, 32'h6);
        chk({31'h0, irq_take}, 32'h0);
        rd(ADDR_IRQ_FLAGS, 8'h50);
        wr(ADDR_IRQ_FLAGS, 8'h00);
        return_from_interrupt_req <= 1'b1;
        @(posedge pclk);
        return_from_interrupt_req <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(ADDR_STACK_GIE, 8'h87);
        wr(ADDR_STACK_GIE, 8'h07);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        $display("test 3 done");
        for (i = 0; i < 2; i++)
        begin
            wr(ADDR_OSC_MODE, 8'h08);
            repeat (3) @(posedge pclk);
            chk({31'h0, cpu_run}, 32'h0);
            chk({31'h0, osc_all_stop}, 32'h1);
            pulse(5'h08);
            chk({31'h0, cpu_run}, 32'h0);
            pulse(5'h01 << i);
            wt(0);
            chk({31'h0, n >= HOLD - 6 && n <= HOLD + 4}, 32'h1);
            rd(ADDR_OSC_MODE, 8'h00);
            wr(ADDR_IRQ_FLAGS, 8'h00);
        end
        $display("test 4 done");
        wr(ADDR_OSC_MODE, 8'h04);
        // the clock pins follow the mode register one edge later
        @(posedge pclk);
        chk({31'h0, clock_mode_select}, 32'h1);
        wr(ADDR_OSC_MODE, 8'h06);
        @(posedge pclk);
        chk({31'h0, high_osc_stop}, 32'h1);
        wr(ADDR_OSC_MODE, 8'h16);
        repeat (3) @(posedge pclk);
        chk({31'h0, cpu_run}, 32'h0);
        chk({31'h0, osc_all_stop}, 32'h0);
        pulse(5'h08);
        chk({31'h0, cpu_run}, 32'h0);
        trun <= 1'b1;
        pulse(5'h08);
        chk({31'h0, cpu_run}, 32'h1);
        chk({31'h0, clock_mode_select}, 32'h1);
        rd(ADDR_OSC_MODE, 8'h06);
        trun <= 1'b0;
        wr(ADDR_OSC_MODE, 8'h16);
        repeat (3) @(posedge pclk);
        chk({31'h0, cpu_run}, 32'h0);
        pulse(5'h04);
        chk({31'h0, cpu_run}, 32'h1);
        wr(ADDR_OSC_MODE, 8'h04);
        repeat (SETTLE) @(posedge pclk);
        wr(ADDR_OSC_MODE, 8'h00);
        @(posedge pclk);
        chk({30'h0, clock_mode_select, high_osc_stop}, 32'h0);
        $display("test 5 done");
        acc      <= 8'hA5;
        pf       <= 8'hFF;
        save_stb <= 1'b1;
        @(posedge pclk);
        save_stb    <= 1'b0;
        acc         <= 8'h00;
        pf          <= 8'h00;
        restore_stb <= 1'b1;
        @(posedge pclk);
        restore_stb <= 1'b0;
        wt(2);
        chk({24'h0, restore_acc}, 32'hA5);
        chk({24'h0, restore_flags}, {24'h0, 8'hFF & PROGRAM_FLAGS_KEEP_MASK});
        $display("test 6 done");
        stop_test();
    end
endmodule // interrupt_and_wakeup_control_test
